// File: svr_regs.svh
`ifndef SVR_REGS_SVH
`define SVR_REGS_SVH

// ==========================================================
// Clock and counter sizing
`define SVR_CLK_MHZ 100
`define SVR_CNT_W 27
`define SVR_DEPTH_W 2
`define SVR_SYNC_W 4
`define SVR_MS_CYC(ms) ((ms) * 1000 * `SVR_CLK_MHZ)
`define SVR_US_CYC(us) ((us) * `SVR_CLK_MHZ)

// ==========================================================
// Durations, least values
`define SVR_HOLD_SHORT_MS 150
`define SVR_HOLD_LONG_MS 1200
`define SVR_PULSE_MS 150
`define SVR_SETTLE_MS 150
`define SVR_MIN_TRIG_US 1

// ==========================================================
// Undershoot qualification per depth code, shallow to deep
`define SVR_QUAL0_US 100
`define SVR_QUAL1_US 50
`define SVR_QUAL2_US 20
`define SVR_QUAL3_US 5

// ==========================================================
// Synchroniser bit positions
`define SVR_SB_SUPPLY 0
`define SVR_SB_TRIG 1
`define SVR_SB_DEPTH 2

`endif

// File: svr_pkg.sv
`default_nettype none
package svr_pkg;
    typedef enum logic [1:0] {
        MAN_ARMED,
        MAN_PULSE,
        MAN_SETTLE
    } svr_man_state_t;
endpackage : svr_pkg
`default_nettype wire

// File: svr_sync.sv
`timescale 1ns/1ns
`default_nettype none
module svr_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    // ==========================================================
    // Two-stage synchroniser, one per bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            logic meta_q;
            logic hold_q;
            always_ff @(posedge clk) begin
                if (rst) begin
                    meta_q <= 1'b0;
                    hold_q <= 1'b0;
                end else begin
                    meta_q <= async_i[i];
                    hold_q <= meta_q;
                end
            end
            assign sync_o[i] = hold_q;
        end
    endgenerate
endmodule : svr_sync
`default_nettype wire

// File: svr_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "svr_regs.svh"
module svr_top import svr_pkg::*; #(
    parameter bit LONG_HOLD = 1'b0,
    parameter bit PUSH_PULL = 1'b1,
    parameter int HOLD_SHORT_CYC = `SVR_MS_CYC(`SVR_HOLD_SHORT_MS),
    parameter int HOLD_LONG_CYC = `SVR_MS_CYC(`SVR_HOLD_LONG_MS),
    parameter int PULSE_CYC = `SVR_MS_CYC(`SVR_PULSE_MS),
    parameter int SETTLE_CYC = `SVR_MS_CYC(`SVR_SETTLE_MS),
    parameter int QUAL0_CYC = `SVR_US_CYC(`SVR_QUAL0_US),
    parameter int QUAL1_CYC = `SVR_US_CYC(`SVR_QUAL1_US),
    parameter int QUAL2_CYC = `SVR_US_CYC(`SVR_QUAL2_US),
    parameter int QUAL3_CYC = `SVR_US_CYC(`SVR_QUAL3_US)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Supply monitor
    input wire logic supply_low,
    input wire logic [`SVR_DEPTH_W-1:0] undershoot_depth,
    // Manual trigger pin
    input wire logic manual_trigger_n,
    input wire logic manual_trigger_float,
    // Reset output pin
    output logic reset_n_o,
    output logic reset_oe
);
    localparam logic [`SVR_CNT_W-1:0] HOLD_CYC =
        LONG_HOLD ? `SVR_CNT_W'(HOLD_LONG_CYC) : `SVR_CNT_W'(HOLD_SHORT_CYC);
    localparam logic [`SVR_CNT_W-1:0] PULSE_LAST = `SVR_CNT_W'(PULSE_CYC - 1);
    localparam logic [`SVR_CNT_W-1:0] SETTLE_LAST = `SVR_CNT_W'(SETTLE_CYC - 1);
    localparam logic [`SVR_CNT_W-1:0] CNT_ZERO = `SVR_CNT_W'(0);
    localparam logic [`SVR_CNT_W-1:0] CNT_ONE = `SVR_CNT_W'(1);

    // ==========================================================
    // Input synchronisation
    logic [`SVR_SYNC_W-1:0] raw_in;
    logic [`SVR_SYNC_W-1:0] sync_in;
    logic supply_low_s;
    logic trig_n_s;
    logic [`SVR_DEPTH_W-1:0] depth_s;

    // Floating pin reads as released
    // Press synchronised active high, so the reset value is idle
    assign raw_in[`SVR_SB_TRIG] = !(manual_trigger_n | manual_trigger_float);
    assign raw_in[`SVR_SB_SUPPLY] = supply_low;
    assign raw_in[`SVR_SB_DEPTH +: `SVR_DEPTH_W] = undershoot_depth;

    svr_sync #(
        .WIDTH(`SVR_SYNC_W)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .async_i(raw_in),
        .sync_o(sync_in)
    );

    assign supply_low_s = sync_in[`SVR_SB_SUPPLY];
    assign trig_n_s = !sync_in[`SVR_SB_TRIG];
    assign depth_s = sync_in[`SVR_SB_DEPTH +: `SVR_DEPTH_W];

    // ==========================================================
    // Undershoot qualification
    logic [`SVR_CNT_W-1:0] qual_lim;
    logic [`SVR_CNT_W-1:0] qual_cnt_q;
    logic qual_low_q;

    always_comb begin
        unique case (depth_s)
            2'h0: qual_lim = `SVR_CNT_W'(QUAL0_CYC - 1);
            2'h1: qual_lim = `SVR_CNT_W'(QUAL1_CYC - 1);
            2'h2: qual_lim = `SVR_CNT_W'(QUAL2_CYC - 1);
            2'h3: qual_lim = `SVR_CNT_W'(QUAL3_CYC - 1);
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            qual_cnt_q <= CNT_ZERO;
        end else if (!supply_low_s) begin
            qual_cnt_q <= CNT_ZERO;
        end else if (qual_cnt_q < qual_lim) begin
            qual_cnt_q <= qual_cnt_q + CNT_ONE;
        end
    end

    // Undershoot must persist for the depth's limit
    always_ff @(posedge clk) begin
        if (rst) begin
            qual_low_q <= 1'b0;
        end else if (!supply_low_s) begin
            qual_low_q <= 1'b0;
        end else if (qual_cnt_q >= qual_lim) begin
            qual_low_q <= 1'b1;
        end
    end

    // ==========================================================
    // Supply recovery hold
    logic [`SVR_CNT_W-1:0] hold_cnt_q;
    logic supply_rst;

    // Power-on starts with a full hold
    always_ff @(posedge clk) begin
        if (rst) begin
            hold_cnt_q <= HOLD_CYC;
        end else if (qual_low_q) begin
            hold_cnt_q <= HOLD_CYC;
        end else if (hold_cnt_q != CNT_ZERO) begin
            hold_cnt_q <= hold_cnt_q - CNT_ONE;
        end
    end

    assign supply_rst = qual_low_q || (hold_cnt_q != CNT_ZERO);

    // ==========================================================
    // Manual one-shot
    svr_man_state_t man_state_q;
    logic trig_prev_q;
    logic trig_fall;
    logic trig_rise;
    logic [`SVR_CNT_W-1:0] pulse_cnt_q;
    logic [`SVR_CNT_W-1:0] settle_cnt_q;
    logic rise_seen_q;
    logic settle_done;

    assign trig_fall = trig_prev_q && !trig_n_s;
    assign trig_rise = !trig_prev_q && trig_n_s;
    assign settle_done = rise_seen_q && (settle_cnt_q == CNT_ZERO);

    always_ff @(posedge clk) begin
        if (rst) begin
            trig_prev_q <= 1'b1;
        end else begin
            trig_prev_q <= trig_n_s;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            man_state_q <= MAN_ARMED;
        end else begin
            unique case (man_state_q)
                MAN_ARMED: begin
                    if (trig_fall) begin
                        man_state_q <= MAN_PULSE;
                    end
                end
                MAN_PULSE: begin
                    if (pulse_cnt_q == CNT_ZERO) begin
                        man_state_q <= MAN_SETTLE;
                    end
                end
                MAN_SETTLE: begin
                    if (settle_done) begin
                        man_state_q <= MAN_ARMED;
                    end
                end
            endcase
        end
    end

    // Only the arming edge loads the pulse length
    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_cnt_q <= CNT_ZERO;
        end else if (man_state_q == MAN_ARMED && trig_fall) begin
            pulse_cnt_q <= PULSE_LAST;
        end else if (pulse_cnt_q != CNT_ZERO) begin
            pulse_cnt_q <= pulse_cnt_q - CNT_ONE;
        end
    end

    // Settling starts at the first rise after the assertion
    always_ff @(posedge clk) begin
        if (rst) begin
            rise_seen_q <= 1'b0;
        end else if (man_state_q == MAN_ARMED) begin
            rise_seen_q <= 1'b0;
        end else if (trig_rise) begin
            rise_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            settle_cnt_q <= CNT_ZERO;
        end else if (man_state_q != MAN_ARMED && !rise_seen_q && trig_rise) begin
            settle_cnt_q <= SETTLE_LAST;
        end else if (settle_cnt_q != CNT_ZERO) begin
            settle_cnt_q <= settle_cnt_q - CNT_ONE;
        end
    end

    // ==========================================================
    // Reset output pin
    logic assert_rst;
    assign assert_rst = supply_rst || (man_state_q == MAN_PULSE);

    always_ff @(posedge clk) begin
        if (rst) begin
            reset_n_o <= 1'b0;
        end else begin
            reset_n_o <= !assert_rst;
        end
    end

    // Open-drain drives only while low
    always_ff @(posedge clk) begin
        if (rst) begin
            reset_oe <= 1'b1;
        end else begin
            reset_oe <= PUSH_PULL ? 1'b1 : assert_rst;
        end
    end

    // ==========================================================
    // Checks
    AST_SUPPLY_LOW: assert property (@(posedge clk) disable iff (rst)
        qual_low_q |=> !reset_n_o)
        else $error("Reset not low while supply qualified low");

    AST_HOLD_RELOAD: assert property (@(posedge clk) disable iff (rst)
        qual_low_q |=> (hold_cnt_q == HOLD_CYC))
        else $error("Hold counter not loaded with option value");

    AST_HOLD_KEEP: assert property (@(posedge clk) disable iff (rst)
        (!qual_low_q && hold_cnt_q != CNT_ZERO) |=> !reset_n_o)
        else $error("Reset released before recovery hold ended");

    AST_GLITCH: assert property (@(posedge clk) disable iff (rst)
        (!qual_low_q && qual_cnt_q < qual_lim) |=> !qual_low_q)
        else $error("Short undershoot qualified too early");

    AST_DEPTH_ORDER: assert property (@(posedge clk) disable iff (rst)
        (supply_low_s && depth_s == 2'h3 && qual_cnt_q >= `SVR_CNT_W'(QUAL3_CYC - 1))
        |=> qual_low_q)
        else $error("Deep undershoot not qualified after its short limit");

    AST_FALL_PULSE: assert property (@(posedge clk) disable iff (rst)
        (man_state_q == MAN_ARMED && trig_fall)
        |=> (man_state_q == MAN_PULSE && pulse_cnt_q == PULSE_LAST) ##1 !reset_n_o)
        else $error("Manual fall did not start pulse");

    AST_ONE_SHOT: assert property (@(posedge clk) disable iff (rst)
        (man_state_q == MAN_PULSE && pulse_cnt_q == CNT_ZERO)
        |=> (man_state_q == MAN_SETTLE))
        else $error("Pulse extended beyond its length");

    AST_IGNORE_FALL: assert property (@(posedge clk) disable iff (rst)
        (man_state_q != MAN_ARMED && pulse_cnt_q != CNT_ZERO)
        |=> (pulse_cnt_q == $past(pulse_cnt_q) - CNT_ONE))
        else $error("Pulse counter disturbed by a later fall");

    AST_REARM: assert property (@(posedge clk) disable iff (rst)
        (man_state_q == MAN_SETTLE && !settle_done) |=> (man_state_q == MAN_SETTLE))
        else $error("One-shot re-armed before settling ended");

    AST_SETTLE_START: assert property (@(posedge clk) disable iff (rst)
        (man_state_q != MAN_ARMED && !rise_seen_q && trig_rise)
        |=> (rise_seen_q && settle_cnt_q == SETTLE_LAST))
        else $error("Settling not timed from first rise");

    AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (rst)
        (!PUSH_PULL && reset_n_o) |-> !reset_oe)
        else $error("Open-drain output driving high");

    AST_FLOAT_HIGH: assert property (@(posedge clk) disable iff (rst)
        manual_trigger_float [*3] |-> trig_n_s)
        else $error("Floating trigger not read as high");

    AST_PULSE_END: assert property (@(posedge clk) disable iff (rst)
        (man_state_q == MAN_SETTLE && !supply_rst) |=> reset_n_o)
        else $error("Held trigger kept reset low after pulse");

    AST_SETTLE_IGNORE: assert property (@(posedge clk) disable iff (rst)
        (man_state_q == MAN_SETTLE && trig_fall) |=> (man_state_q != MAN_PULSE))
        else $error("Fall during settling started a pulse");

    AST_LOW_DRIVEN: assert property (@(posedge clk) disable iff (rst)
        !reset_n_o |-> reset_oe)
        else $error("Reset low but output not driven");

    AST_PP_DRIVE: assert property (@(posedge clk) disable iff (rst)
        PUSH_PULL |-> reset_oe)
        else $error("Push-pull output not driven");

    COV_MANUAL: cover property (@(posedge clk) disable iff (rst)
        (man_state_q == MAN_PULSE) ##1 (man_state_q == MAN_SETTLE));

    COV_REARM: cover property (@(posedge clk) disable iff (rst)
        (man_state_q == MAN_SETTLE) ##1 (man_state_q == MAN_ARMED));

    COV_SUPPLY: cover property (@(posedge clk) disable iff (rst)
        $fell(qual_low_q) ##1 !reset_n_o);

    COV_GLITCH: cover property (@(posedge clk) disable iff (rst)
        (supply_low_s && !qual_low_q) ##1 !supply_low_s);

    COV_BOUNCE: cover property (@(posedge clk) disable iff (rst)
        (man_state_q == MAN_SETTLE) && trig_fall);
endmodule : svr_top
`default_nettype wire

// File: svr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Host reset input and pushbutton
module svr_host_model (
    // Clock
    input wire logic clk,
    // Supervisor reset pin
    input wire logic reset_n_o,
    input wire logic reset_oe,
    // Pin views
    output logic reset_line,
    output logic trig_n,
    output int low_runs
);
    int run = 0;
    int cnt = 0;

    // Pull-up holds the line high when released
    assign reset_line = reset_oe ? reset_n_o : 1'h1;
    assign low_runs = cnt;
    initial trig_n = 1'h1;

    // Count finished low runs of the host reset line
    always @(posedge clk) begin
        if (reset_line === 1'h0) begin
            run <= run + 1;
        end else if (run != 0) begin
            cnt <= cnt + 1;
            run <= 0;
        end
    end

    // Press for hold cycles, then an optional release bounce
    task automatic press(input int hold, input bit bounce);
        trig_n = 1'h0;
        repeat (hold) @(posedge clk);
        #1 trig_n = 1'h1;
        if (bounce) begin
            repeat (5) @(posedge clk);
            #1 trig_n = 1'h0;
            repeat (4) @(posedge clk);
            #1 trig_n = 1'h1;
        end
    endtask : press
endmodule : svr_host_model
`default_nettype wire

// File: tb_svr_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "svr_regs.svh"
module tb_svr_top;
    localparam int HS = 40;
    localparam int HL = 80;
    localparam int PL = 30;
    localparam int ST = 20;
    localparam int Q0 = 16;
    localparam int Q1 = 8;
    localparam int Q2 = 4;
    localparam int Q3 = 2;
    localparam bit OPT_OFF = 1'h0;
    localparam bit OPT_ON = 1'h1;
    int qual[4] = '{Q0, Q1, Q2, Q3};
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic supply_low = 1'h0;
    logic [`SVR_DEPTH_W-1:0] depth = '0;
    logic trig_float = 1'h0;
    wire logic a_n, a_oe, b_n, b_oe, line_a, trig_n;
    int runs;
    int miscompares = 0;
    int checks = 0;

    always #5 clk = ~clk;

    svr_top #(.LONG_HOLD(OPT_OFF), .PUSH_PULL(OPT_OFF), .HOLD_SHORT_CYC(HS), .HOLD_LONG_CYC(HL),
        .PULSE_CYC(PL), .SETTLE_CYC(ST), .QUAL0_CYC(Q0), .QUAL1_CYC(Q1), .QUAL2_CYC(Q2),
        .QUAL3_CYC(Q3)) dut (.clk(clk), .rst(rst), .supply_low(supply_low),
        .undershoot_depth(depth), .manual_trigger_n(trig_n), .manual_trigger_float(trig_float),
        .reset_n_o(a_n), .reset_oe(a_oe));
    svr_top #(.LONG_HOLD(OPT_ON), .PUSH_PULL(OPT_ON), .HOLD_SHORT_CYC(HS), .HOLD_LONG_CYC(HL),
        .PULSE_CYC(PL), .SETTLE_CYC(ST), .QUAL0_CYC(Q0), .QUAL1_CYC(Q1), .QUAL2_CYC(Q2),
        .QUAL3_CYC(Q3)) dut_long (.clk(clk), .rst(rst), .supply_low(supply_low),
        .undershoot_depth(depth), .manual_trigger_n(trig_n), .manual_trigger_float(trig_float),
        .reset_n_o(b_n), .reset_oe(b_oe));
    svr_host_model host (.clk(clk), .reset_n_o(a_n), .reset_oe(a_oe), .reset_line(line_a),
        .trig_n(trig_n), .low_runs(runs));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    function automatic logic in_win(input int n, input int lo, input int hi);
        return (n >= lo && n <= hi);
    endfunction : in_win

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    // Wait for the line to go low, then count cycles until it is high
    task automatic low_len(input bit b, output int n);
        int i;
        n = 0;
        for (i = 0; i < 30 && (b ? b_n : line_a) !== 1'h0; i++) cyc(1);
        while ((b ? b_n : line_a) !== 1'h1 && n < 3000) begin
            cyc(1);
            n++;
        end
    endtask : low_len

    task automatic results();
        $display("count checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // Tests take under two thousand cycles; this leaves ample margin
    initial begin
        repeat (10000) @(posedge clk);
        miscompares++;
        results();
    end

    initial begin
        int na, nb, r0, i, d;
        void'($urandom(47));
        cyc(4);
        rst = 1'h0;
        fork
            low_len(1'h0, na);
            low_len(1'h1, nb);
        join
        check("por_short", in_win(na, HS, HS + 4), 1'h1);
        check("por_long", in_win(nb, HL, HL + 4), 1'h1);
        $display("test power_on done");

        // ==========================================
        // Undershoots at each depth
        for (d = 0; d < 4; d++) begin
            depth = d[1:0];
            r0 = runs;
            supply_low = 1'h1;
            cyc(qual[d] - 1);
            supply_low = 1'h0;
            cyc(12);
            check("glitch_runs", runs, r0);
            supply_low = 1'h1;
            cyc(qual[d] + 6);
            check("qual_low", line_a, 1'h0);
            check("od_oe_low", a_oe, 1'h1);
            cyc($urandom_range(1, 20));
            supply_low = 1'h0;
            fork
                low_len(1'h0, na);
                low_len(1'h1, nb);
            join
            check("hold_short", in_win(na, HS, HS + 6), 1'h1);
            check("hold_long", in_win(nb, HL, HL + 6), 1'h1);
            check("od_oe_high", a_oe, 1'h0);
            check("pp_oe", b_oe, 1'h1);
        end
        $display("test supply done");

        // ==========================================
        // Manual one-shot with bounce and re-arm
        for (i = 0; i < 3; i++) begin
            cyc(40);
            r0 = runs;
            fork
                host.press(i == 0 ? 100 : $urandom_range(100, 200), 1'h1);
                low_len(1'h0, na);
                low_len(1'h1, nb);
            join
            check("pulse_len", in_win(na, PL, PL + 3), 1'h1);
            check("pulse_len_long", in_win(nb, PL, PL + 3), 1'h1);
            cyc(40);
            check("bounce_runs", runs, r0 + 1);
            fork
                host.press(100, 1'h0);
                low_len(1'h0, na);
            join
            check("rearm_len", in_win(na, PL, PL + 3), 1'h1);
        end
        $display("test manual done");

        cyc(40);
        r0 = runs;
        trig_float = 1'h1;
        host.press(120, 1'h0);
        cyc(10);
        trig_float = 1'h0;
        cyc(10);
        check("float_runs", runs, r0);
        $display("test float done");
        results();
    end
endmodule : tb_svr_top
`default_nettype wire
